// ### rtl/acc_decoder_defs.svh
`ifndef ACC_DECODER_DEFS_SVH
`define ACC_DECODER_DEFS_SVH

// Accessible configuration variable window.
`define CV_FIRST 10'h201
`define CV_LAST 10'h209
`define CV_COUNT 9
`define CV_IDX_CARD_LO 4'h0
`define CV_IDX_LOCAL 4'h1
`define CV_IDX_ON_A 4'h2
`define CV_IDX_ON_D 4'h5
`define CV_IDX_VERSION 4'h6
`define CV_IDX_ARM 4'h7
`define CV_IDX_CARD_HI 4'h8
`define CARD_LO_MAX 8'h3F
`define ARM_VALUE 8'h00

// Factory defaults.
`define DEF_CARD_LO 8'h01
`define DEF_LOCAL 8'h55
`define DEF_ON_TIME 8'h02
`define DEF_VERSION 8'h01
// Arbitrary maker code, not tied to any real part.
`define DEF_MAKER 8'h5A
`define DEF_CARD_HI 8'h00

// Register word indices; 0 to 8 are the variables themselves.
`define REG_STATUS 4'h9
`define REG_CTRL 4'hA
`define ST_RESTORED 0
`define ST_ARMED 1
`define ST_BUSY 2
`define ST_MATCH 3
`define CTRL_OPS_EN 0
`define CTRL_RESET 32'h0000_0001

// Timing.
`define CLK_HZ 20000000
`define FLASH_MS 100
`define TENTH_MS 100
`define FLASH_CYCLES (`CLK_HZ / 1000 * `FLASH_MS)
`define TENTH_CYCLES (`CLK_HZ / 1000 * `TENTH_MS)
`define SYNC_WAIT 2'h3

`endif

// ### rtl/acc_decoder_pkg.sv
`default_nettype none
package acc_decoder_pkg;
  typedef logic [7:0] cv_byte_t;
  typedef enum logic [1:0] {RS_SETTLE, RS_WRITE, RS_FLASH, RS_RUN} restore_state_e;
endpackage
`default_nettype wire

// ### rtl/output_pulse_timer.sv
`default_nettype none
module output_pulse_timer #(
  parameter int TENTH_CYCLES = 2000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic [7:0] on_time,
  output logic out_q
);
  logic [31:0] pre_q;
  logic [7:0] tenths_q;
  logic tick;

  assign tick = (pre_q == 32'(TENTH_CYCLES - 1));

  // The on-time is sampled only at activation, so a rewrite acts next time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      tenths_q <= 8'h00;
      pre_q <= 32'h0000_0000;
    end else if (start) begin
      out_q <= 1'b1;
      tenths_q <= on_time;
      pre_q <= 32'h0000_0000;
    end else if (stop) begin
      out_q <= 1'b0;
      tenths_q <= 8'h00;
    end else if (out_q && tenths_q != 8'h00) begin
      pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      if (tick) begin
        tenths_q <= tenths_q - 8'h01;
        if (tenths_q == 8'h01) begin
          out_q <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_drives: assert property (start |=> out_q)
    else $error("output not driven after activation");
  a_zero_holds: assert property (out_q && tenths_q == 8'h00 && !start && !stop |=> out_q)
    else $error("continuous output dropped");
endmodule // output_pulse_timer
`default_nettype wire

// ### rtl/acc_decoder_cv_access.sv
`include "acc_decoder_defs.svh"
`default_nettype none
module acc_decoder_cv_access
  import acc_decoder_pkg::*;
#(
  parameter int FLASH_CYCLES = `FLASH_CYCLES,
  parameter int TENTH_CYCLES = `TENTH_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic NV_BLANK,
  input wire logic PKT_VALID,
  input wire logic [8:0] PKT_CARD,
  input wire logic [9:0] PKT_CV,
  input wire logic PKT_VERIFY,
  input wire logic PKT_BIT_MODE,
  input wire logic [7:0] PKT_VALUE,
  input wire logic ACT_VALID,
  input wire logic [10:0] ACT_ADDR,
  input wire logic ACT_ON,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic ACK_LED,
  output logic STAT_LED,
  output logic [3:0] OUTPUTS
);

  function automatic logic cv_in_range(input logic [9:0] cv);
    cv_in_range = (cv >= `CV_FIRST) && (cv <= `CV_LAST);
  endfunction

  function automatic cv_byte_t cv_default(input logic [3:0] idx);
    case (idx)
      `CV_IDX_CARD_LO: cv_default = `DEF_CARD_LO;
      `CV_IDX_LOCAL: cv_default = `DEF_LOCAL;
      `CV_IDX_VERSION: cv_default = `DEF_VERSION;
      `CV_IDX_ARM: cv_default = `DEF_MAKER;
      `CV_IDX_CARD_HI: cv_default = `DEF_CARD_HI;
      default: cv_default = `DEF_ON_TIME;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and strap synchronisers.

  logic rst_meta_q;
  logic rst_n_s;
  logic blank_meta_q;
  logic blank_q;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s <= rst_meta_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      blank_meta_q <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      blank_meta_q <= NV_BLANK;
      blank_q <= blank_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Variable store and restore sequencer.

  // The store and the arm flag model nonvolatile memory and are never reset.
  cv_byte_t cv_q [`CV_COUNT];
  logic arm_q;
  restore_state_e rs_q;
  logic [3:0] ridx_q;
  logic [1:0] settle_q;
  logic restored_q;
  logic [31:0] ctrl_q;
  logic run;
  logic [8:0] card;
  logic [3:0] pidx;
  logic pkt_mine;
  logic pkt_ok;
  logic pkt_wr;
  logic pkt_vfy;
  logic vfy_hit;
  logic bus_go;
  logic bus_wr;
  logic ack_q;
  logic [31:0] ack_cnt_q;

  assign run = (rs_q == RS_RUN);
  assign card = {cv_q[`CV_IDX_CARD_HI][2:0], cv_q[`CV_IDX_CARD_LO][5:0]};
  assign pidx = 4'(PKT_CV - `CV_FIRST);
  assign pkt_mine = PKT_VALID && run && ctrl_q[`CTRL_OPS_EN] && PKT_CARD != 9'h000
                    && PKT_CARD == card;
  assign pkt_ok = pkt_mine && cv_in_range(PKT_CV) && !PKT_BIT_MODE;
  assign pkt_wr = pkt_ok && !PKT_VERIFY
                  && !(pidx == `CV_IDX_CARD_LO && PKT_VALUE > `CARD_LO_MAX);
  assign pkt_vfy = pkt_ok && PKT_VERIFY;
  assign vfy_hit = pkt_vfy && cv_q[pidx] == PKT_VALUE;
  assign bus_go = !AVS_WAITREQUEST && run;
  assign bus_wr = bus_go && AVS_WRITE && AVS_ADDRESS < 4'(`CV_COUNT);

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rs_q <= RS_SETTLE;
      ridx_q <= 4'h0;
      settle_q <= 2'h0;
      restored_q <= 1'b0;
    end else begin
      case (rs_q)
        RS_SETTLE: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == `SYNC_WAIT) begin
            rs_q <= (arm_q || blank_q) ? RS_WRITE : RS_RUN;
          end
        end
        RS_WRITE: begin
          ridx_q <= ridx_q + 4'h1;
          if (ridx_q == 4'(`CV_COUNT - 1)) begin
            rs_q <= RS_FLASH;
          end
        end
        RS_FLASH: begin
          if (ack_q && ack_cnt_q == 32'h0000_0000) begin
            restored_q <= 1'b1;
            rs_q <= RS_RUN;
          end
        end
        RS_RUN: rs_q <= RS_RUN;
        default: rs_q <= RS_SETTLE;
      endcase
    end
  end

  // A packet write lands after a bus write to the same variable.
  always_ff @(posedge REF_CLK) begin
    if (rs_q == RS_WRITE) begin
      cv_q[ridx_q] <= cv_default(ridx_q);
    end else begin
      if (bus_wr && AVS_ADDRESS != `CV_IDX_ARM) begin
        cv_q[AVS_ADDRESS] <= AVS_WRITEDATA[7:0];
      end
      if (pkt_wr && pidx != `CV_IDX_ARM) begin
        cv_q[pidx] <= PKT_VALUE;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rs_q == RS_WRITE) begin
      arm_q <= 1'b0;
    end else if ((pkt_wr && pidx == `CV_IDX_ARM && PKT_VALUE == `ARM_VALUE)
                 || (bus_wr && AVS_ADDRESS == `CV_IDX_ARM
                     && AVS_WRITEDATA[7:0] == `ARM_VALUE)) begin
      arm_q <= 1'b1;
    end else if (rs_q == RS_SETTLE && settle_q == 2'h0 && arm_q !== 1'b1) begin
      arm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator LEDs.

  logic ack_fire;
  logic stat_fire;
  logic stat_q;
  logic [31:0] stat_cnt_q;
  logic stat_flash_q;

  assign ack_fire = pkt_wr || vfy_hit || (rs_q == RS_FLASH && !ack_q);
  assign stat_fire = pkt_wr || pkt_vfy;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ack_q <= 1'b0;
      ack_cnt_q <= 32'h0000_0000;
    end else if (ack_fire && !ack_q) begin
      ack_q <= 1'b1;
      ack_cnt_q <= 32'(FLASH_CYCLES - 1);
    end else if (ack_cnt_q != 32'h0000_0000) begin
      ack_cnt_q <= ack_cnt_q - 32'h0000_0001;
    end else begin
      ack_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      stat_flash_q <= 1'b0;
      stat_cnt_q <= 32'h0000_0000;
    end else if (stat_fire) begin
      stat_flash_q <= 1'b1;
      stat_cnt_q <= 32'(FLASH_CYCLES - 1);
    end else if (stat_cnt_q != 32'h0000_0000) begin
      stat_cnt_q <= stat_cnt_q - 32'h0000_0001;
    end else begin
      stat_flash_q <= 1'b0;
    end
  end

  // Green is steady after a restore; a flash inverts it for its duration.
  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      stat_q <= 1'b0;
    end else begin
      stat_q <= restored_q ^ stat_flash_q;
    end
  end

  assign ACK_LED = ack_q;
  assign STAT_LED = stat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Accessory outputs.

  logic [10:0] act_base;
  logic act_hit;
  logic [3:0] out_w;

  assign act_base = ACT_ADDR - 11'h001;
  assign act_hit = ACT_VALID && ACT_ADDR != 11'h000 && run
                   && act_base[10:2] == card - 9'h001;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_out
      output_pulse_timer #(
        .TENTH_CYCLES(TENTH_CYCLES)
      ) u_timer (
        .clk(REF_CLK),
        .rst_n(rst_n_s),
        .start(act_hit && ACT_ON && act_base[1:0] == 2'(i)),
        .stop(act_hit && !ACT_ON && act_base[1:0] == 2'(i)),
        .on_time(cv_q[`CV_IDX_ON_A + 4'(i)]),
        .out_q(out_w[i])
      );
    end
  endgenerate

  assign OUTPUTS = out_w;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, then one cycle with waitrequest low.

  logic wait_q;
  logic [31:0] rdata_q;
  logic match_q;

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ && wait_q) begin
      if (AVS_ADDRESS < 4'(`CV_COUNT)) begin
        rdata_q <= {24'h00_0000, cv_q[AVS_ADDRESS]};
      end else if (AVS_ADDRESS == `REG_STATUS) begin
        rdata_q <= {28'h000_0000, match_q, !run, arm_q, restored_q};
      end else if (AVS_ADDRESS == `REG_CTRL) begin
        rdata_q <= ctrl_q;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_q <= `CTRL_RESET;
    end else if (!AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == `REG_CTRL) begin
      ctrl_q <= {31'h0000_0000, AVS_WRITEDATA[`CTRL_OPS_EN]};
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      match_q <= 1'b0;
    end else if (pkt_vfy) begin
      match_q <= vfy_hit;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_s);

  a_ack_on_write: assert property (pkt_wr && !ack_q |=> ACK_LED)
    else $error("receipt LED not lit after write");
  a_card_zero: assert property (
      PKT_VALID && PKT_CARD == 9'h000 && !ack_q |=> !ack_q)
    else $error("LED lit for card number zero");
  a_foreign_card: assert property (
      PKT_VALID && PKT_CARD != card && !ack_q |=> !ack_q)
    else $error("LED lit for another card");
  a_verify_hit: assert property (vfy_hit && !ack_q |=> ack_q ##1 ack_q)
    else $error("matching verify gave no flash");
  a_verify_miss: assert property (
      pkt_vfy && !vfy_hit && !ack_q |=> !ack_q)
    else $error("mismatching verify flashed");
  a_range_ignore: assert property (
      PKT_VALID && !cv_in_range(PKT_CV) && !ack_q |=> !ack_q)
    else $error("out of range packet flashed");
  a_arm_not_kept: assert property (
      pkt_wr && pidx == `CV_IDX_ARM && !bus_wr |=> arm_q == ($past(PKT_VALUE) == 8'h00)
      || $past(arm_q))
    else $error("arming write mishandled");
  a_arm_value_kept: assert property (
      run && pkt_wr && pidx == `CV_IDX_ARM |=> $stable(cv_q[`CV_IDX_ARM]))
    else $error("arming value stored");
  a_restore_done: assert property (
      rs_q == RS_FLASH |-> cv_q[`CV_IDX_ON_A] == `DEF_ON_TIME
      && cv_q[`CV_IDX_CARD_LO] == `DEF_CARD_LO)
    else $error("defaults not written before flash");
  a_green_after: assert property ($rose(restored_q) |-> $past(ack_q) ##2 STAT_LED)
    else $error("green not lit after restore");

endmodule // acc_decoder_cv_access
`default_nettype wire

// ### bench/cmd_station_model.sv
`default_nettype none
module cmd_station_model (
  input wire logic clk,
  output logic pkt_valid,
  output logic [8:0] pkt_card,
  output logic [9:0] pkt_cv,
  output logic pkt_verify,
  output logic pkt_bit_mode,
  output logic [7:0] pkt_value
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    pkt_valid = 1'b0;
    pkt_card = 9'h000;
    pkt_cv = 10'h000;
    pkt_verify = 1'b0;
    pkt_bit_mode = 1'b0;
    pkt_value = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sends one packet; idle fields show the inverse so stale values never match.
  task automatic send(input logic [8:0] card, input logic [9:0] cv, input logic verify,
                      input logic bit_mode, input logic [7:0] value);
    @(posedge clk);
    pkt_card <= card;
    pkt_cv <= cv;
    pkt_verify <= verify;
    pkt_bit_mode <= bit_mode;
    pkt_value <= value;
    pkt_valid <= 1'b1;
    @(posedge clk);
    pkt_valid <= 1'b0;
    pkt_card <= ~card;
    pkt_cv <= ~cv;
    pkt_verify <= ~verify;
    pkt_bit_mode <= ~bit_mode;
    pkt_value <= ~value;
    // Completion here only means the packet went out; nothing is read back.
  endtask
endmodule // cmd_station_model
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic NV_BLANK = 1'b1;
  logic ACT_VALID = 1'b0;
  logic [10:0] ACT_ADDR = 11'h000;
  logic ACT_ON = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic PKT_VALID, PKT_VERIFY, PKT_BIT_MODE, AVS_WAITREQUEST, ACK_LED, STAT_LED;
  logic [8:0] PKT_CARD;
  logic [9:0] PKT_CV;
  logic [7:0] PKT_VALUE;
  logic [31:0] AVS_READDATA;
  logic [3:0] OUTPUTS;
  logic [31:0] rd;
  logic ack_seen = 1'b0;
  int num_errors = 0;
  int comparisons = 0;

  initial forever #25 REF_CLK = ~REF_CLK;

  cmd_station_model cmd_station_model_inst (.clk(REF_CLK), .pkt_valid(PKT_VALID),
    .pkt_card(PKT_CARD), .pkt_cv(PKT_CV), .pkt_verify(PKT_VERIFY),
    .pkt_bit_mode(PKT_BIT_MODE), .pkt_value(PKT_VALUE));

  acc_decoder_cv_access #(.FLASH_CYCLES(8), .TENTH_CYCLES(4)) acc_decoder_cv_access_inst (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .NV_BLANK(NV_BLANK), .PKT_VALID(PKT_VALID),
    .PKT_CARD(PKT_CARD), .PKT_CV(PKT_CV), .PKT_VERIFY(PKT_VERIFY),
    .PKT_BIT_MODE(PKT_BIT_MODE), .PKT_VALUE(PKT_VALUE), .ACT_VALID(ACT_VALID),
    .ACT_ADDR(ACT_ADDR), .ACT_ON(ACT_ON), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .ACK_LED(ACK_LED), .STAT_LED(STAT_LED),
    .OUTPUTS(OUTPUTS));

  // Remembers any red flash seen since the last reset.
  always @(posedge REF_CLK) begin
    if (RST_N !== 1'b1) ack_seen <= 1'b0;
    else if (ACK_LED === 1'b1) ack_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic power_up(input logic blank);
    @(posedge REF_CLK);
    RST_N <= 1'b0;
    NV_BLANK <= blank;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (40) @(posedge REF_CLK);
  endtask

  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    int n = 0;
    @(posedge REF_CLK);
    AVS_ADDRESS <= idx;
    AVS_WRITEDATA <= wd;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    chk(n < 50, 1, "bus answer");
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp, input string msg);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp, msg);
  endtask

  task automatic pkt(input logic [8:0] c, input logic [9:0] v, input logic vf,
                     input logic bm, input logic [7:0] x);
    cmd_station_model_inst.send(c, v, vf, bm, x);
  endtask

  task automatic expect_ack(input logic exp, input string msg);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge REF_CLK);
      #1;
      if (ACK_LED === 1'b1) seen = 1'b1;
    end
    chk(seen, exp, msg);
    repeat (12) @(posedge REF_CLK);
  endtask

  task automatic act(input logic [10:0] addr, input logic on);
    @(posedge REF_CLK);
    ACT_VALID <= 1'b1;
    ACT_ADDR <= addr;
    ACT_ON <= on;
    @(posedge REF_CLK);
    ACT_VALID <= 1'b0;
    ACT_ADDR <= ~addr;
    ACT_ON <= ~on;
  endtask

  task automatic wait_out(input int n, input int bitn, input logic exp, input string msg);
    repeat (n) @(posedge REF_CLK);
    #1;
    chk(OUTPUTS[bitn], exp, msg);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_restore;
    chk(ack_seen, 1, "red flash after restore");
    chk(STAT_LED, 1, "green steady after restore");
    rd_chk(4'h0, 32'h1, "card low default");
    rd_chk(4'h2, 32'h2, "on-time A default");
    rd_chk(4'h5, 32'h2, "on-time D default");
    rd_chk(4'h8, 32'h0, "card high default");
    rd_chk(4'hA, 32'h1, "ctrl reset");
    rd_chk(4'hF, 32'h0, "unmapped read");
    $display("test restore done");
  endtask

  task automatic t_write;
    logic s;
    pkt(9'd1, 10'd515, 1'b0, 1'b0, 8'd0);
    s = ~STAT_LED;
    repeat (3) @(posedge REF_CLK);
    #1;
    chk(STAT_LED, s, "green flashes on programming");
    expect_ack(1, "write ack");
    rd_chk(4'h2, 32'h0, "on-time A written");
    $display("test write done");
  endtask

  task automatic t_verify_refuse;
    pkt(9'd1, 10'd515, 1'b1, 1'b0, 8'd0);
    expect_ack(1, "verify match");
    bus(1'b0, 4'h9, 32'h0000_0000);
    chk(rd & 32'h8, 32'h8, "match flag set");
    pkt(9'd1, 10'd515, 1'b1, 1'b0, 8'd1);
    expect_ack(0, "verify mismatch");
    bus(1'b0, 4'h9, 32'h0000_0000);
    chk(rd & 32'h8, 32'h0, "match flag cleared");
    pkt(9'd1, 10'd515, 1'b1, 1'b1, 8'd0);
    expect_ack(0, "bit verify");
    pkt(9'd2, 10'd515, 1'b0, 1'b0, 8'd9);
    expect_ack(0, "foreign card");
    bus(1'b1, 4'h0, 32'h0000_0000);
    rd_chk(4'h0, 32'h0, "bus variable write");
    pkt(9'd0, 10'd515, 1'b0, 1'b0, 8'd9);
    expect_ack(0, "card zero");
    bus(1'b1, 4'h0, 32'h0000_0001);
    bus(1'b1, 4'hA, 32'h0000_0000);
    pkt(9'd1, 10'd515, 1'b0, 1'b0, 8'd9);
    expect_ack(0, "ops programming disabled");
    bus(1'b1, 4'hA, 32'h0000_0001);
    pkt(9'd1, 10'd512, 1'b0, 1'b0, 8'd9);
    expect_ack(0, "cv below window");
    pkt(9'd1, 10'd522, 1'b0, 1'b0, 8'd9);
    expect_ack(0, "cv above window");
    rd_chk(4'h2, 32'h0, "refused kept store");
    $display("test verify and refuse done");
  endtask

  task automatic t_pulse;
    act(11'd1, 1'b1);
    wait_out(20, 0, 1, "on-time zero continuous");
    act(11'd1, 1'b0);
    wait_out(2, 0, 0, "off clears");
    pkt(9'd1, 10'd515, 1'b0, 1'b0, 8'd3);
    expect_ack(1, "on-time write");
    chk(OUTPUTS, 4'h0, "write does not activate");
    act(11'd1, 1'b1);
    wait_out(6, 0, 1, "pulse A high");
    wait_out(10, 0, 0, "pulse A ended");
    act(11'd4, 1'b1);
    wait_out(4, 3, 1, "pulse D high");
    wait_out(8, 3, 0, "pulse D ended");
    $display("test pulse done");
  endtask

  task automatic t_card_arm;
    pkt(9'd1, 10'd513, 1'b0, 1'b0, 8'd64);
    expect_ack(0, "card low over limit");
    pkt(9'd1, 10'd521, 1'b0, 1'b0, 8'd1);
    expect_ack(1, "card high write");
    pkt(9'd65, 10'd515, 1'b1, 1'b0, 8'd3);
    expect_ack(1, "new card answers");
    act(11'd257, 1'b1);
    wait_out(2, 0, 1, "new card output A");
    wait_out(14, 0, 0, "new card pulse ended");
    pkt(9'd65, 10'd520, 1'b0, 1'b0, 8'd7);
    expect_ack(1, "nonzero arm write");
    bus(1'b0, 4'h9, 32'h0000_0000);
    chk(rd & 32'h2, 32'h0, "nonzero does not arm");
    pkt(9'd1, 10'd520, 1'b0, 1'b0, 8'd0);
    expect_ack(0, "arm to other card");
    bus(1'b0, 4'h9, 32'h0000_0000);
    chk(rd & 32'h2, 32'h0, "other card not armed");
    pkt(9'd65, 10'd520, 1'b0, 1'b0, 8'd0);
    expect_ack(1, "arm write");
    bus(1'b0, 4'h9, 32'h0000_0000);
    chk(rd & 32'h2, 32'h2, "armed");
    rd_chk(4'h7, 32'h5A, "arm value not stored");
    $display("test card and arm done");
  endtask

  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test;
  end

  initial begin
    power_up(1'b1);
    t_restore;
    t_write;
    t_verify_refuse;
    t_pulse;
    t_card_arm;
    power_up(1'b0);
    t_restore;
    finish_test;
  end
endmodule // tb
`default_nettype wire
